// [hdl/mrr_pkg.sv]
// Shared constants, field layouts and carrier types for the region register file.
package mrr_pkg;

  // Coprocessor encodings that this block claims.
  localparam logic [3:0] MRR_COPROC         = 4'hf;
  localparam logic [3:0] MRR_CRN_REGION     = 4'h6;
  localparam logic [2:0] MRR_OPC1_INDIRECT  = 3'h0;
  localparam logic [3:0] MRR_CRM_INDIRECT   = 4'h3;
  localparam logic [2:0] MRR_OPC2_IND_LIMIT = 3'h1;
  localparam logic [1:0] MRR_OPC1_DIR_HIGH  = 2'h0;
  localparam logic       MRR_CRM_DIR_TOP    = 1'h1;
  localparam logic [1:0] MRR_OPC2_DIR_BASE  = 2'h0;
  localparam logic [1:0] MRR_OPC2_DIR_LIMIT = 2'h1;

  // Field positions within the base and limit words.
  localparam int MRR_ADDR_LSB  = 6;
  localparam int MRR_SH_LSB    = 3;
  localparam int MRR_AP_LSB    = 1;
  localparam int MRR_ATTR_LSB  = 1;
  localparam int MRR_ATTR_HIGH = 3;
  localparam int MRR_XN_BIT    = 0;
  localparam int MRR_EN_BIT    = 0;

  // Writable bits, bound padding and reset values.
  localparam logic [31:0] MRR_BASE_MASK   = 32'hffffffdf;
  localparam logic [31:0] MRR_LIMIT_MASK  = 32'hffffffcf;
  localparam logic [5:0]  MRR_LOW_PAD     = 6'h00;
  localparam logic [5:0]  MRR_HIGH_PAD    = 6'h3f;
  localparam logic [31:0] MRR_WORD_RESET  = 32'h00000000;
  localparam int          MRR_DIRECT_MAX  = 32;

  // Privilege level codes presented by the core.
  localparam logic [1:0] MRR_LVL_USER   = 2'h0;
  localparam logic [1:0] MRR_LVL_KERNEL = 2'h1;
  localparam logic [1:0] MRR_LVL_HYP    = 2'h2;

  typedef enum logic [1:0] {
    MRR_SH_NONE, MRR_SH_RESERVED, MRR_SH_OUTER, MRR_SH_INNER
  } mrr_share_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  level;
    logic [3:0]  coproc;
    logic [2:0]  opc1;
    logic [3:0]  crn;
    logic [3:0]  crm;
    logic [2:0]  opc2;
    logic [31:0] wdata;
  } mrr_req_t;

  typedef struct packed {
    logic general_trap_control;
    logic vm_write_trap;
    logic vm_read_trap;
    logic system_trap_bit_ten;
    logic system_trap_bit_six;
  } mrr_trap_ctl_t;

  typedef struct packed {
    logic        valid;
    logic        trap_hyp;
    logic        undef;
    logic [31:0] rdata;
  } mrr_resp_t;

  typedef struct packed {
    logic [31:0] lower;
    logic [31:0] upper;
    mrr_share_t  share;
    logic        kernel_write;
    logic        user_read;
    logic        user_write;
    logic        exec_never;
    logic        attr_high;
    logic [1:0]  attr_slot;
    logic        enable;
  } mrr_view_t;

endpackage

// [hdl/mrr_decode.sv]
// Decoder from a coprocessor encoding to the region register it names.
`timescale 1ns/1ps
module mrr_decode
  import mrr_pkg::*;
(
  // Request
  input  wire mrr_req_t   req,
  // Decoded target
  output logic            hit_direct,
  output logic            hit_indirect,
  output logic            is_limit,
  output logic [4:0]      region_idx
);

  logic common;

  always_comb begin
    common       = (req.coproc == MRR_COPROC) && (req.crn == MRR_CRN_REGION);
    hit_indirect = common && (req.opc1 == MRR_OPC1_INDIRECT) &&
                   (req.crm == MRR_CRM_INDIRECT) && (req.opc2 == MRR_OPC2_IND_LIMIT);
    hit_direct   = common && (req.opc1[2:1] == MRR_OPC1_DIR_HIGH) &&
                   (req.crm[3] == MRR_CRM_DIR_TOP) &&
                   ((req.opc2[1:0] == MRR_OPC2_DIR_BASE) ||
                    (req.opc2[1:0] == MRR_OPC2_DIR_LIMIT));
    is_limit     = hit_indirect || (req.opc2[1:0] == MRR_OPC2_DIR_LIMIT);
    region_idx   = {req.opc1[0], req.crm[2:0], req.opc2[2]};
  end

endmodule

// [hdl/mrr_slot.sv]
// Storage for one region: its base word and its limit word.
`timescale 1ns/1ps
module mrr_slot
  import mrr_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // Write strobes
  input  wire logic        wr_base,
  input  wire logic        wr_limit,
  input  wire logic [31:0] wdata,
  // Stored words
  output logic [31:0]      base_word,
  output logic [31:0]      limit_word
);

  typedef struct packed {
    logic [31:0] base;
    logic [31:0] limit;
  } mrr_slot_state_t;

  mrr_slot_state_t st_ff;
  mrr_slot_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (wr_base) begin
      nxt_st.base = wdata & MRR_BASE_MASK;
    end
    if (wr_limit) begin
      nxt_st.limit = wdata & MRR_LIMIT_MASK;
    end
  end

  // Only the enable bit has a fixed reset; zero is one legal choice for the other fields.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_ff.base  <= MRR_WORD_RESET;
      st_ff.limit <= MRR_WORD_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign base_word  = st_ff.base;
  assign limit_word = st_ff.limit;

endmodule

// [hdl/mrr_region_file.sv]
// Kernel-level protection region register file with coprocessor access and trap checks.
//
// Operation
// - Base bits 31:6 with six zero bits give the inclusive lower bound.
// - Limit bits 31:6 with low bits all ones give the inclusive upper bound.
// - Shareability bits 4:3 decode none, reserved, outer and inner.
// - Permission bits 2:1 decode kernel/user read-write and read-only combinations.
// - Attribute index 0-3 selects low indirection slots, 4-7 the high ones.
// - Limit bit 0 enables the region and resets to zero.
// - All other region fields reset to an unspecified value.
// - The indirect limit register reaches the region the selector names.
// - Separate direct base and limit registers cover the first 32 regions.
// - Direct base encoding is cp15, CRn 6, opc1/CRm/opc2 built from n.
// - Direct limit encoding matches base except opc2 low bits are 01.
// - Indirect limit sits at cp15, opc1 0, CRn 6, CRm 3, opc2 1.
// - Direct encodings at or beyond the implemented region count are unallocated.
// - With the write trap set, kernel writes trap to hypervisor.
// - With the read trap set, kernel reads trap to hypervisor.
// - System trap bit ten traps kernel access to direct registers.
// - System trap bit six traps kernel access to the indirect limit.
`timescale 1ns/1ps
module mrr_region_file
  import mrr_pkg::*;
#(
  parameter int NUM_REGIONS = 16
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          resetn,
  // Coprocessor transfer from the core
  input  wire mrr_req_t      cp_req,
  // Hypervisor trap controls and current region selector
  input  wire mrr_trap_ctl_t trap_ctl,
  input  wire logic [7:0]    region_selector_reg,
  // Answer to the core
  output mrr_resp_t          cp_resp,
  // Region view for the matching logic
  input  wire logic [4:0]    view_idx,
  output mrr_view_t          region_view,
  output logic [31:0]        region_enable
);

  localparam int IDX_W = 5;

  // The direct encodings only carry a five-bit region number.
  if (NUM_REGIONS < 1 || NUM_REGIONS > MRR_DIRECT_MAX) begin : g_bad_count
    $error("NUM_REGIONS must lie between 1 and 32.");
  end

  typedef struct packed {
    mrr_resp_t resp;
    mrr_view_t view;
    logic [31:0] enables;
  } mrr_state_t;

  mrr_state_t st_ff;
  mrr_state_t nxt_st;

  // Decoded request.
  logic             dec_direct;
  logic             dec_indirect;
  logic             dec_limit;
  logic [IDX_W-1:0] dec_idx;

  // Region storage.
  logic [31:0] base_words  [NUM_REGIONS];
  logic [31:0] limit_words [NUM_REGIONS];
  logic [NUM_REGIONS-1:0] wr_base_vec;
  logic [NUM_REGIONS-1:0] wr_limit_vec;

  // Access evaluation.
  logic             target_idx_ok;
  logic [IDX_W-1:0] target_idx;
  logic             claimed;
  logic             unallocated;
  logic             denied;
  logic             trapped;
  logic             commit_write;
  logic [31:0]      read_word;

  // View evaluation.
  logic [31:0] view_base;
  logic [31:0] view_limit;
  logic        view_ok;

  mrr_decode u_decode (
    .req          (cp_req),
    .hit_direct   (dec_direct),
    .hit_indirect (dec_indirect),
    .is_limit     (dec_limit),
    .region_idx   (dec_idx)
  );

  // One slot per implemented region; direct encodings above the count have no storage.
  for (genvar g = 0; g < NUM_REGIONS; g++) begin : g_slot
    mrr_slot u_slot (
      .mclk       (mclk),
      .resetn     (resetn),
      .wr_base    (wr_base_vec[g]),
      .wr_limit   (wr_limit_vec[g]),
      .wdata      (cp_req.wdata),
      .base_word  (base_words[g]),
      .limit_word (limit_words[g])
    );
  end

  // Target region and the access decision.
  always_comb begin
    claimed = cp_req.valid && (dec_direct || dec_indirect);
    if (dec_indirect) begin
      // A selector at or above the count is unpredictable; it is answered as undefined.
      target_idx_ok = (region_selector_reg < 8'(NUM_REGIONS));
      target_idx    = region_selector_reg[IDX_W-1:0];
    end else begin
      target_idx_ok = (32'(dec_idx) < 32'(NUM_REGIONS));
      target_idx    = dec_idx;
    end
    unallocated = !target_idx_ok;
    denied = (cp_req.level == MRR_LVL_USER) ||
             ((cp_req.level == MRR_LVL_KERNEL) && trap_ctl.general_trap_control) ||
             (cp_req.level > MRR_LVL_HYP);
    trapped = 1'b0;
    if (cp_req.level == MRR_LVL_KERNEL) begin
      if (dec_direct && trap_ctl.system_trap_bit_ten) begin
        trapped = 1'b1;
      end
      if (dec_indirect && trap_ctl.system_trap_bit_six) begin
        trapped = 1'b1;
      end
      if (cp_req.write && trap_ctl.vm_write_trap) begin
        trapped = 1'b1;
      end
      if (!cp_req.write && trap_ctl.vm_read_trap) begin
        trapped = 1'b1;
      end
    end
    commit_write = claimed && cp_req.write && !unallocated && !denied && !trapped;
  end

  // Write strobes into the slots and the word read back.
  always_comb begin
    wr_base_vec  = '0;
    wr_limit_vec = '0;
    read_word    = 32'h00000000;
    for (int i = 0; i < NUM_REGIONS; i++) begin
      if (commit_write && (target_idx == IDX_W'(i))) begin
        wr_base_vec[i]  = !dec_limit;
        wr_limit_vec[i] = dec_limit;
      end
      if (target_idx_ok && (target_idx == IDX_W'(i))) begin
        read_word = dec_limit ? limit_words[i] : base_words[i];
      end
    end
  end

  // Region chosen for the matching logic.
  always_comb begin
    view_ok    = (32'(view_idx) < 32'(NUM_REGIONS));
    view_base  = 32'h00000000;
    view_limit = 32'h00000000;
    for (int i = 0; i < NUM_REGIONS; i++) begin
      if (view_idx == IDX_W'(i)) begin
        view_base  = base_words[i];
        view_limit = limit_words[i];
      end
    end
  end

  // Next state: answer, decoded view and the enable vector.
  always_comb begin
    nxt_st = st_ff;

    // Answer the core one cycle after a claimed request; encodings of
    // other registers are left for the blocks that own them.
    nxt_st.resp.valid    = claimed;
    nxt_st.resp.undef    = 1'b0;
    nxt_st.resp.trap_hyp = 1'b0;
    nxt_st.resp.rdata    = 32'h00000000;
    if (claimed) begin
      if (unallocated || denied) begin
        nxt_st.resp.undef = 1'b1;
      end else if (trapped) begin
        nxt_st.resp.trap_hyp = 1'b1;
      end else if (!cp_req.write) begin
        nxt_st.resp.rdata = read_word;
      end
    end

    // Bounds.
    nxt_st.view.lower = {view_base[31:MRR_ADDR_LSB], MRR_LOW_PAD};
    nxt_st.view.upper = {view_limit[31:MRR_ADDR_LSB], MRR_HIGH_PAD};

    // Shareability; the reserved code is passed on for the matcher to treat.
    nxt_st.view.share = mrr_share_t'(view_base[MRR_SH_LSB +: 2]);

    // Permission: the high bit makes the region read-only, the low bit opens it to user level.
    nxt_st.view.kernel_write = !view_base[MRR_AP_LSB + 1];
    nxt_st.view.user_read    = view_base[MRR_AP_LSB];
    nxt_st.view.user_write   = view_base[MRR_AP_LSB] && !view_base[MRR_AP_LSB + 1];

    nxt_st.view.exec_never = view_base[MRR_XN_BIT];

    // Attribute slot and which indirection register holds it.
    nxt_st.view.attr_high = view_limit[MRR_ATTR_HIGH];
    nxt_st.view.attr_slot = view_limit[MRR_ATTR_LSB +: 2];

    // A view index at or beyond the count shows a disabled region.
    nxt_st.view.enable = view_ok && view_limit[MRR_EN_BIT];

    nxt_st.enables = '0;
    for (int i = 0; i < NUM_REGIONS; i++) begin
      nxt_st.enables[i] = limit_words[i][MRR_EN_BIT];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cp_resp       = st_ff.resp;
  assign region_view   = st_ff.view;
  assign region_enable = st_ff.enables;

endmodule

// [testbench/mrr_core_model.sv]
// Core side model that issues coprocessor transfers to the region register file.
`timescale 1ns/1ps
module mrr_core_model
  import mrr_pkg::*;
(
  // Clock
  input  wire logic mclk,
  // Transfer to the block
  output mrr_req_t  cp_req
);
  initial cp_req = '0;
  // One-cycle pulse; afterwards every field is inverted so that no stale value reads as valid.
  task automatic issue(input logic wr, input logic [1:0] lvl, input logic [2:0] o1,
                       input logic [3:0] cm, input logic [2:0] o2, input logic [31:0] wd);
    @(posedge mclk) #1;
    cp_req = '{1'b1, wr, lvl, MRR_COPROC, o1, MRR_CRN_REGION, cm, o2, wd};
    @(posedge mclk) #1;
    cp_req = {1'b0, ~cp_req[$bits(mrr_req_t)-2:0]};
  endtask
endmodule

// [testbench/mrr_region_file_asserts.sv]
// Concurrent checks on the ports of the region register file.
`timescale 1ns/1ps
module mrr_region_file_asserts
  import mrr_pkg::*;
#(
  parameter int NUM_REGIONS = 16
) (
  // Clock and reset
  input wire logic          mclk,
  input wire logic          resetn,
  // Core side
  input wire mrr_req_t      cp_req,
  input wire mrr_trap_ctl_t trap_ctl,
  input wire logic [7:0]    region_selector_reg,
  input wire mrr_resp_t     cp_resp,
  // Region view
  input wire logic [4:0]    view_idx,
  input wire mrr_view_t     region_view,
  input wire logic [31:0]   region_enable
);
  logic       dir;
  logic       ind;
  logic       ok;
  logic       k1;
  logic [4:0] n;
  assign n = {cp_req.opc1[0], cp_req.crm[2:0], cp_req.opc2[2]};
  assign dir = cp_req.valid && cp_req.coproc == MRR_COPROC && cp_req.crn == MRR_CRN_REGION
             && cp_req.opc1[2:1] == 2'h0 && cp_req.crm[3] && cp_req.opc2[1:0] <= 2'h1;
  assign ind = cp_req.valid && cp_req.coproc == MRR_COPROC && cp_req.crn == MRR_CRN_REGION
             && cp_req.opc1 == 3'h0 && cp_req.crm == 4'h3 && cp_req.opc2 == 3'h1;
  assign ok = dir ? (int'(n) < NUM_REGIONS) : (int'(region_selector_reg) < NUM_REGIONS);
  // Kernel access past the allocation and level checks, the only kind that may trap.
  assign k1 = (dir || ind) && ok && cp_req.level == MRR_LVL_KERNEL
            && !trap_ctl.general_trap_control;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_claim_answer: assert property ((dir || ind) |=> cp_resp.valid)
    else $error("claimed transfer not answered");
  a_other_silent: assert property (!(dir || ind) |=> !cp_resp.valid)
    else $error("unclaimed transfer answered");
  a_unalloc_undef: assert property ((dir || ind) && !ok |=> cp_resp.undef)
    else $error("unallocated region not undefined");
  a_user_undef: assert property ((dir || ind) && cp_req.level == MRR_LVL_USER
    |=> cp_resp.undef && !cp_resp.trap_hyp) else $error("user access not refused");
  a_hyp_pass: assert property ((dir || ind) && ok && cp_req.level == MRR_LVL_HYP
    |=> !cp_resp.undef && !cp_resp.trap_hyp) else $error("hypervisor access refused");
  a_write_trap: assert property (k1 && cp_req.write && trap_ctl.vm_write_trap
    |=> cp_resp.trap_hyp && !cp_resp.undef) else $error("kernel write not trapped");
  a_read_trap: assert property (k1 && !cp_req.write && trap_ctl.vm_read_trap
    |=> cp_resp.trap_hyp) else $error("kernel read not trapped");
  a_ten_trap: assert property (k1 && dir && trap_ctl.system_trap_bit_ten
    |=> cp_resp.trap_hyp) else $error("direct access not trapped");
  a_six_trap: assert property (k1 && ind && trap_ctl.system_trap_bit_six
    |=> cp_resp.trap_hyp) else $error("indirect access not trapped");
  a_refused_zero: assert property (cp_resp.valid && (cp_resp.trap_hyp || cp_resp.undef)
    |-> cp_resp.rdata == 32'h0) else $error("refused transfer returned data");
  a_view_pads: assert property ($past(resetn) && int'($past(view_idx)) < NUM_REGIONS
    |-> region_view.lower[5:0] == 6'h00 && region_view.upper[5:0] == 6'h3f)
    else $error("bound padding wrong");
  a_view_enable: assert property (region_view.enable == region_enable[$past(view_idx)])
    else $error("view enable differs from enable vector");
endmodule

bind mrr_region_file mrr_region_file_asserts #(.NUM_REGIONS(NUM_REGIONS)) u_asserts (
  .mclk(mclk), .resetn(resetn), .cp_req(cp_req), .trap_ctl(trap_ctl),
  .region_selector_reg(region_selector_reg), .cp_resp(cp_resp), .view_idx(view_idx),
  .region_view(region_view), .region_enable(region_enable));

// [testbench/testbench.sv]
// Self-checking bench for the region register file against a queue-free array model.
`timescale 1ns/1ps
module testbench;
  import mrr_pkg::*;
  localparam int NR = 16;
  logic          mclk;
  logic          resetn;
  mrr_req_t      cp_req;
  mrr_trap_ctl_t trap_ctl;
  logic [7:0]    region_selector_reg;
  mrr_resp_t     cp_resp;
  logic [4:0]    view_idx;
  mrr_view_t     region_view;
  logic [31:0]   region_enable;
  logic [31:0]   bm [32];
  logic [31:0]   lm [32];
  int            fail_count;
  int            total_checks;
  int            cycles;

  mrr_core_model core (.mclk(mclk), .cp_req(cp_req));
  mrr_region_file #(.NUM_REGIONS(NR)) dut (.mclk(mclk), .resetn(resetn), .cp_req(cp_req),
    .trap_ctl(trap_ctl), .region_selector_reg(region_selector_reg), .cp_resp(cp_resp),
    .view_idx(view_idx), .region_view(region_view), .region_enable(region_enable));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task results;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Kind 0 is a direct base, 1 a direct limit, 2 the indirect limit through the selector.
  task automatic acc(input logic wr, input logic [1:0] lvl, input int kind, input int n,
                     input logic [31:0] wd);
    logic [4:0]  m;
    int          r;
    logic        un;
    logic        tr;
    logic [31:0] rd;
    m = n[4:0];
    r = (kind == 2) ? int'(region_selector_reg) : n;
    un = r >= NR || lvl == MRR_LVL_USER || lvl == 2'h3
       || (lvl == MRR_LVL_KERNEL && trap_ctl.general_trap_control);
    tr = !un && lvl == MRR_LVL_KERNEL && ((kind != 2 && trap_ctl.system_trap_bit_ten)
       || (kind == 2 && trap_ctl.system_trap_bit_six) || (wr && trap_ctl.vm_write_trap)
       || (!wr && trap_ctl.vm_read_trap));
    rd = 32'h0;
    if (!un && !tr) begin
      if (wr && kind == 0) bm[r] = wd & 32'hffffffdf;
      else if (wr) lm[r] = wd & 32'hffffffcf;
      else rd = (kind == 0) ? bm[r] : lm[r];
    end
    if (kind == 2) core.issue(wr, lvl, 3'h0, 4'h3, 3'h1, wd);
    else core.issue(wr, lvl, {2'h0, m[4]}, {1'b1, m[3:1]}, {m[0], 1'b0, kind == 1}, wd);
    chk("resp_valid", 32'h1, cp_resp.valid);
    chk("undef", un, cp_resp.undef);
    chk("trap_hyp", tr, cp_resp.trap_hyp);
    chk("rdata", rd, cp_resp.rdata);
  endtask

  task automatic vchk(input int n);
    logic [31:0] b;
    logic [31:0] l;
    b = bm[n];
    l = lm[n];
    view_idx = n[4:0];
    @(posedge mclk) #1;
    chk("enable_vec", l[0], region_enable[n]);
    if (n < NR) begin
      chk("lower", {b[31:6], 6'h00}, region_view.lower);
      chk("upper", {l[31:6], 6'h3f}, region_view.upper);
      chk("attrs", {b[4:3], ~b[2], b[1], b[1] & ~b[2], b[0], l[3:1], l[0]},
          region_view[9:0]);
    end else chk("view_enable", 32'h0, region_view.enable);
  endtask

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 8000) begin
      fail_count++;
      results();
    end
  end

  initial begin
    resetn = 1'b0;
    trap_ctl = '0;
    region_selector_reg = 8'h00;
    view_idx = 5'h00;
    fail_count = 0;
    total_checks = 0;
    cycles = 0;
    for (int i = 0; i < 32; i++) begin
      bm[i] = 32'h0;
      lm[i] = 32'h0;
    end
    void'($urandom(64));
    repeat (4) @(posedge mclk);
    #1 resetn = 1'b1;
    chk("enable_reset", 32'h0, region_enable);
    // Every region number, including the unallocated ones above the implemented count.
    for (int n = 0; n < 32; n++) begin
      acc(1'b1, MRR_LVL_KERNEL, 0, n, $urandom);
      acc(1'b1, MRR_LVL_KERNEL, 1, n, $urandom);
      acc(1'b0, MRR_LVL_KERNEL, 0, n, 32'h0);
      acc(1'b0, MRR_LVL_KERNEL, 1, n, 32'h0);
      region_selector_reg = n[7:0];
      acc(1'b1, MRR_LVL_HYP, 2, n, $urandom);
      acc(1'b0, MRR_LVL_KERNEL, 2, n, 32'h0);
      vchk(n);
    end
    // Random levels and trap controls cover every refusal path.
    repeat (300) begin
      trap_ctl = 5'($urandom);
      region_selector_reg = 8'($urandom_range(0, 20));
      acc(1'($urandom), 2'($urandom), $urandom_range(0, 2), $urandom_range(0, 20),
          $urandom);
      vchk($urandom_range(0, 31));
    end
    // A reset in mid-run must clear every enable that the random writes left set.
    resetn = 1'b0;
    #1 chk("enable_mid_reset", 32'h0, region_enable);
    for (int i = 0; i < 32; i++) begin
      bm[i] = 32'h0;
      lm[i] = 32'h0;
    end
    @(posedge mclk) #1 resetn = 1'b1;
    acc(1'b0, MRR_LVL_HYP, 1, 3, 32'h0);
    vchk(3);
    results();
  end
endmodule
